// ### design/ecc_pkg.sv
// Purpose: Shared constants and types for the edge capture counter link channel.
// Assumes: Single 50 MHz clock, synchronous active-high reset.
// Notes: Encodings of modes, polarities and service levels are fixed here.
`default_nettype none
package ecc_pkg;
	// =========================================================
	// Widths
	localparam int ECC_TIME_W = 24;
	localparam int ECC_COUNT_W = 24;
	localparam int ECC_WORD_W = 32;
	localparam int ECC_FIELD_W = 8;
	localparam int ECC_NUM_TARGETS = 8;
	localparam int ECC_FILT_W = 8;
	// =========================================================
	// Target field layout
	localparam int ECC_ENG_HI = 7;
	localparam int ECC_ENG_LO = 6;
	localparam int ECC_CHAN_HI = 3;
	localparam int ECC_CHAN_LO = 0;
	localparam logic [1:0] ECC_ENG_THIS = 2'h0;
	localparam logic [1:0] ECC_ENG_ONE = 2'h1;
	localparam logic [1:0] ECC_ENG_TWO = 2'h2;
	localparam logic [1:0] ECC_ENG_OTHER = 2'h3;
	// =========================================================
	// Reset values
	localparam logic [23:0] ECC_COUNT_RST = 24'h00_0000;
	localparam logic [23:0] ECC_TIME_RST = 24'h00_0000;
	localparam logic [7:0] ECC_FILT_RST = 8'h00;
	// =========================================================
	// Encodings
	typedef enum logic [1:0] {
		ECC_MODE_ONE_EDGE = 2'h0,
		ECC_MODE_FREE_RUN = 2'h1,
		ECC_MODE_OUTBOUND = 2'h2
	} ecc_mode_t;
	typedef enum logic [1:0] {
		ECC_POL_RISING = 2'h0,
		ECC_POL_FALLING = 2'h1,
		ECC_POL_BOTH = 2'h2
	} ecc_pol_t;
	typedef enum logic [1:0] {
		ECC_LVL_OFF = 2'h0,
		ECC_LVL_BOTTOM = 2'h1,
		ECC_LVL_MID = 2'h2,
		ECC_LVL_TOP = 2'h3
	} ecc_level_t;
	typedef enum logic [3:0] {
		ECC_ST_IDLE = 4'h1,
		ECC_ST_ARMED = 4'h2,
		ECC_ST_LINK = 4'h4,
		ECC_ST_DONE = 4'h8
	} ecc_state_t;
endpackage
`default_nettype wire

// ### design/ecc_glitch_filter.sv
// Purpose: Digital glitch filter on the capture pin.
// Assumes: Pin is synchronous to clock.
// Notes: A new level is taken only after it holds for more than filterLen clocks.
`default_nettype none
module ecc_glitch_filter (
	input wire logic clock,
	input wire logic srst,
	input wire logic pinIn,
	input wire logic [7:0] filterLen,
	output logic pinOut
);
	logic [7:0] runCnt_reg, runCnt_next;
	logic level_reg, level_next;

	always_comb begin
		runCnt_next = ecc_pkg::ECC_FILT_RST;
		level_next = level_reg;
		if (pinIn != level_reg) begin
			if (runCnt_reg >= filterLen) begin
				level_next = pinIn;
			end else begin
				runCnt_next = runCnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			runCnt_reg <= ecc_pkg::ECC_FILT_RST;
			level_reg <= 1'b0;
		end else begin
			runCnt_reg <= runCnt_next;
			level_reg <= level_next;
		end
	end

	assign pinOut = level_reg;
endmodule
`default_nettype wire

// ### design/ecc_link_sender.sv
// Purpose: Walks the first targetCount of the eight packed target fields and issues one link per cycle.
// Assumes: start pulses only while idle.
// Notes: Zero fields are still sent; channel 0 of this engine is a valid target.
`default_nettype none
module ecc_link_sender (
	input wire logic clock,
	input wire logic srst,
	input wire logic start,
	input wire logic [31:0] targetWordFirst,
	input wire logic [31:0] targetWordSecond,
	input wire logic [7:0] targetCount,
	output logic busy,
	output logic linkValid,
	output logic [7:0] linkField
);
	logic [3:0] index_reg, index_next;
	logic busy_reg, busy_next;
	logic valid_reg, valid_next;
	logic [7:0] field_reg, field_next;
	logic [7:0] fields [0:7];

	// =========================================================
	// Field unpacking
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gUnpack
			assign fields[g] = targetWordFirst[g*8 +: 8];
			assign fields[g+4] = targetWordSecond[g*8 +: 8];
		end
	endgenerate

	always_comb begin
		index_next = index_reg;
		busy_next = busy_reg;
		valid_next = 1'b0;
		field_next = field_reg;
		if (!busy_reg) begin
			if (start && targetCount != 8'h00) begin
				busy_next = 1'b1;
				index_next = 4'h0;
			end
		end else begin
			valid_next = 1'b1;
			field_next = fields[index_reg[2:0]];
			index_next = index_reg + 4'h1;
			if ({4'h0, index_reg} + 8'h01 >= targetCount || index_reg == 4'h7) begin
				busy_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			index_reg <= 4'h0;
			busy_reg <= 1'b0;
			valid_reg <= 1'b0;
			field_reg <= 8'h00;
		end else begin
			index_reg <= index_next;
			busy_reg <= busy_next;
			valid_reg <= valid_next;
			field_reg <= field_next;
		end
	end

	assign busy = busy_reg;
	assign linkValid = valid_reg;
	assign linkField = field_reg;
endmodule
`default_nettype wire

// ### design/ecc_channel.sv
// Purpose: Capture channel that counts filtered edges, stamps them and sends links.
// Assumes: Time counters and pin are synchronous to clock.
// Notes: Configuration is latched on the init pulse; change mode only while disabled.
`default_nettype none
// Contract
// - Count rising, falling or both edges.
// - Stamp every captured edge with selected counter.
// - Timebase is primary or secondary counter.
// - One-edge mode captures one edge, stops.
// - Free-running mode captures while enabled.
// - Outbound mode links at count, keeps counting.
// - 24-bit limit; reaching it raises exception.
// - Limit taken literally, no offset.
// - Link targets address any of 64 channels; code reaches only channels 0-15 and 32-47.
// - Incoming link requests are ignored.
// - Pin filtered against short pulses.
// - Two 32-bit words, four 8-bit targets each.
// - Top bits engine, low bits channel number.
// - Engine 11 other, 00 this engine.
// - Engine code 10 only from other/self.
// - Four service levels set at init.
// - Final edge timestamp readable.
// - Counting continues past the limit.
module ecc_channel (
	input wire logic clock,
	input wire logic srst,
	input wire logic capturePin,
	input wire logic [7:0] filterLen,
	input wire logic [23:0] primaryTimeCounter,
	input wire logic [23:0] secondaryTimeCounter,
	input wire logic initStrobe,
	input wire logic channelEnable,
	input wire logic [1:0] serviceLevel,
	input wire logic [1:0] modeSelect,
	input wire logic timebaseSelect,
	input wire logic [1:0] polaritySelect,
	input wire logic [23:0] edgeLimit,
	input wire logic [31:0] targetWordFirst,
	input wire logic [31:0] targetWordSecond,
	input wire logic [7:0] targetCount,
	input wire logic linkIn,
	output logic [23:0] edgeCount,
	output logic [23:0] lastTime,
	output logic [23:0] finalTime,
	output logic exceptionReq,
	output logic captureDone,
	output logic linkValid,
	output logic linkToOther,
	output logic [1:0] linkEngine,
	output logic [5:0] linkChannel,
	output logic [1:0] activeLevel
);
	// =========================================================
	// Decoding helpers
	function automatic logic ecc_edge_hit(input logic [1:0] pol, input logic rise,
			input logic fall);
		case (pol)
			ecc_pkg::ECC_POL_RISING: ecc_edge_hit = rise;
			ecc_pkg::ECC_POL_FALLING: ecc_edge_hit = fall;
			ecc_pkg::ECC_POL_BOTH: ecc_edge_hit = rise | fall;
			default: ecc_edge_hit = 1'b0;
		endcase
	endfunction

	// =========================================================
	// Filter and edge detection
	logic filtPin;
	logic prevPin_reg, prevPin_next;
	ecc_glitch_filter uFilter (
		.clock(clock),
		.srst(srst),
		.pinIn(capturePin),
		.filterLen(filterLen),
		.pinOut(filtPin)
	);

	// =========================================================
	// Configuration and state
	ecc_pkg::ecc_state_t state_reg, state_next;
	logic [1:0] mode_reg, mode_next;
	logic [1:0] pol_reg, pol_next;
	logic tb_reg, tb_next;
	logic [1:0] level_reg, level_next;
	logic [23:0] limit_reg, limit_next;
	logic [31:0] wordA_reg, wordA_next;
	logic [31:0] wordB_reg, wordB_next;
	logic [7:0] tcount_reg, tcount_next;
	logic [23:0] count_reg, count_next;
	logic [23:0] last_reg, last_next;
	logic [23:0] final_reg, final_next;
	logic exc_reg, exc_next;
	logic done_reg, done_next;
	logic linkStart;
	logic hit;
	logic [23:0] stamp;
	logic [23:0] countInc;
	logic senderBusy;
	logic sendValid;
	logic [7:0] sendField;

	assign hit = ecc_edge_hit(pol_reg, filtPin & ~prevPin_reg, ~filtPin & prevPin_reg);
	assign stamp = tb_reg ? secondaryTimeCounter : primaryTimeCounter;
	assign countInc = count_reg + 24'h00_0001;

	always_comb begin
		prevPin_next = filtPin;
		state_next = state_reg;
		mode_next = mode_reg;
		pol_next = pol_reg;
		tb_next = tb_reg;
		level_next = level_reg;
		limit_next = limit_reg;
		wordA_next = wordA_reg;
		wordB_next = wordB_reg;
		tcount_next = tcount_reg;
		count_next = count_reg;
		last_next = last_reg;
		final_next = final_reg;
		exc_next = 1'b0;
		done_next = done_reg;
		linkStart = 1'b0;
		if (initStrobe) begin
			mode_next = modeSelect;
			pol_next = polaritySelect;
			tb_next = timebaseSelect;
			level_next = serviceLevel;
			limit_next = edgeLimit;
			wordA_next = targetWordFirst;
			wordB_next = targetWordSecond;
			tcount_next = targetCount;
			count_next = ecc_pkg::ECC_COUNT_RST;
			last_next = ecc_pkg::ECC_TIME_RST;
			final_next = ecc_pkg::ECC_TIME_RST;
			done_next = 1'b0;
			state_next = ecc_pkg::ECC_ST_ARMED;
		end else if (!channelEnable || level_reg == ecc_pkg::ECC_LVL_OFF) begin
			state_next = ecc_pkg::ECC_ST_IDLE;
		end else begin
			case (state_reg)
				ecc_pkg::ECC_ST_IDLE: begin
					state_next = ecc_pkg::ECC_ST_IDLE;
				end
				ecc_pkg::ECC_ST_ARMED, ecc_pkg::ECC_ST_LINK: begin
					if (hit) begin
						count_next = countInc;
						last_next = stamp;
						final_next = stamp;
						if (countInc == limit_reg) begin
							exc_next = 1'b1;
							if (mode_reg == ecc_pkg::ECC_MODE_OUTBOUND) begin
								linkStart = 1'b1;
								state_next = ecc_pkg::ECC_ST_LINK;
							end
						end
						if (mode_reg == ecc_pkg::ECC_MODE_ONE_EDGE) begin
							done_next = 1'b1;
							state_next = ecc_pkg::ECC_ST_DONE;
						end
					end
				end
				ecc_pkg::ECC_ST_DONE: begin
					state_next = ecc_pkg::ECC_ST_DONE;
				end
				default: begin
					state_next = ecc_pkg::ECC_ST_IDLE;
				end
			endcase
		end
		// Received links have no effect on this channel.
		if (linkIn) begin
			state_next = state_next;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			prevPin_reg <= 1'b0;
			state_reg <= ecc_pkg::ECC_ST_IDLE;
			mode_reg <= ecc_pkg::ECC_MODE_ONE_EDGE;
			pol_reg <= ecc_pkg::ECC_POL_RISING;
			tb_reg <= 1'b0;
			level_reg <= ecc_pkg::ECC_LVL_OFF;
			limit_reg <= ecc_pkg::ECC_COUNT_RST;
			wordA_reg <= 32'h0000_0000;
			wordB_reg <= 32'h0000_0000;
			tcount_reg <= 8'h00;
			count_reg <= ecc_pkg::ECC_COUNT_RST;
			last_reg <= ecc_pkg::ECC_TIME_RST;
			final_reg <= ecc_pkg::ECC_TIME_RST;
			exc_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			prevPin_reg <= prevPin_next;
			state_reg <= state_next;
			mode_reg <= mode_next;
			pol_reg <= pol_next;
			tb_reg <= tb_next;
			level_reg <= level_next;
			limit_reg <= limit_next;
			wordA_reg <= wordA_next;
			wordB_reg <= wordB_next;
			tcount_reg <= tcount_next;
			count_reg <= count_next;
			last_reg <= last_next;
			final_reg <= final_next;
			exc_reg <= exc_next;
			done_reg <= done_next;
		end
	end

	// =========================================================
	// Link issue
	ecc_link_sender uSender (
		.clock(clock),
		.srst(srst),
		.start(linkStart && !senderBusy),
		.targetWordFirst(wordA_reg),
		.targetWordSecond(wordB_reg),
		.targetCount(tcount_reg),
		.busy(senderBusy),
		.linkValid(sendValid),
		.linkField(sendField)
	);

	logic lv_reg, lv_next;
	logic lo_reg, lo_next;
	logic [1:0] le_reg, le_next;
	logic [5:0] lc_reg, lc_next;

	always_comb begin
		lv_next = sendValid;
		le_next = sendField[ecc_pkg::ECC_ENG_HI:ecc_pkg::ECC_ENG_LO];
		lc_next = {2'h0, sendField[ecc_pkg::ECC_CHAN_HI:ecc_pkg::ECC_CHAN_LO]};
		// Other engine targets map to the upper half of the 64-channel space.
		lo_next = (le_next == ecc_pkg::ECC_ENG_OTHER);
		if (lo_next) begin
			lc_next = lc_next | 6'h20;
		end
		// Code 10 is never originated by this channel; it is dropped here.
		if (le_next == ecc_pkg::ECC_ENG_TWO) begin
			lv_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			lv_reg <= 1'b0;
			lo_reg <= 1'b0;
			le_reg <= 2'h0;
			lc_reg <= 6'h00;
		end else begin
			lv_reg <= lv_next;
			lo_reg <= lo_next;
			le_reg <= le_next;
			lc_reg <= lc_next;
		end
	end

	assign edgeCount = count_reg;
	assign lastTime = last_reg;
	assign finalTime = final_reg;
	assign exceptionReq = exc_reg;
	assign captureDone = done_reg;
	assign linkValid = lv_reg;
	assign linkToOther = lo_reg;
	assign linkEngine = le_reg;
	assign linkChannel = lc_reg;
	assign activeLevel = level_reg;
endmodule
`default_nettype wire

// ### verification/ecc_pin_model.sv
// Purpose: Model of the signal source on the capture pin.
// Assumes: Pin is synchronous to clock and idles low.
// Notes: Pulse width is given in clocks.
`default_nettype none
module ecc_pin_model (
	input wire logic clock,
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pinLevel = 1'b0;
	// Rest time covers the filter delay so each call leaves the count settled.
	task automatic pulse(input int width);
		@(posedge clock) #2 pinLevel = 1'b1;
		repeat (width) @(posedge clock);
		#2 pinLevel = 1'b0;
		repeat (12) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ### verification/ecc_channel_monitor.sv
// Purpose: Concurrent checks on the capture channel ports.
// Assumes: Bench holds configuration ports steady while the channel runs.
// Notes: Bound to every ecc_channel instance.
`default_nettype none
module ecc_channel_monitor (
	input wire logic clock,
	input wire logic srst,
	input wire logic capturePin,
	input wire logic [7:0] filterLen,
	input wire logic [23:0] primaryTimeCounter,
	input wire logic [23:0] secondaryTimeCounter,
	input wire logic initStrobe,
	input wire logic channelEnable,
	input wire logic [1:0] serviceLevel,
	input wire logic [1:0] modeSelect,
	input wire logic timebaseSelect,
	input wire logic [1:0] polaritySelect,
	input wire logic [23:0] edgeLimit,
	input wire logic [31:0] targetWordFirst,
	input wire logic [31:0] targetWordSecond,
	input wire logic [7:0] targetCount,
	input wire logic linkIn,
	input wire logic [23:0] edgeCount,
	input wire logic [23:0] lastTime,
	input wire logic [23:0] finalTime,
	input wire logic exceptionReq,
	input wire logic captureDone,
	input wire logic linkValid,
	input wire logic linkToOther,
	input wire logic [1:0] linkEngine,
	input wire logic [5:0] linkChannel,
	input wire logic [1:0] activeLevel
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// =========================================================
	// Sequences
	sequence s_limit_hit;
		exceptionReq && modeSelect == 2'h2 && targetCount != 8'h00;
	endsequence
	sequence s_first_link;
		##2 linkValid;
	endsequence
	// =========================================================
	// Checks
	a_count_step: assert property ($changed(edgeCount) && !$past(initStrobe) |-> edgeCount == $past(edgeCount) + 24'h00_0001) else $error("count step");
	a_init_clears: assert property (initStrobe |=> edgeCount == 24'h00_0000 && !captureDone) else $error("init clear");
	a_stamp_edge: assert property ($changed(edgeCount) && !$past(initStrobe) |-> lastTime == (timebaseSelect ? $past(secondaryTimeCounter) : $past(primaryTimeCounter)) && finalTime == lastTime) else $error("stamp");
	a_done_one: assert property (captureDone && !initStrobe |-> edgeCount == 24'h00_0001) else $error("done count");
	a_done_frozen: assert property (captureDone && $past(captureDone) |-> $stable(edgeCount) && $stable(lastTime)) else $error("done frozen");
	a_exc_pulse: assert property (exceptionReq |-> edgeCount == edgeLimit && $changed(edgeCount) ##1 !exceptionReq) else $error("exception");
	a_link_follows: assert property (s_limit_hit |-> s_first_link) else $error("link late");
	a_link_fields: assert property (linkValid && (linkEngine == 2'h3 || linkEngine == 2'h0) |-> linkToOther == linkEngine[1] && linkChannel[5] == linkEngine[1]) else $error("link field");
	a_no_eng_two: assert property (linkValid |-> linkEngine != 2'h2) else $error("engine code");
	a_level_latched: assert property ($changed(activeLevel) |-> $past(initStrobe)) else $error("level");
endmodule
bind ecc_channel ecc_channel_monitor i_mon (.*);
`default_nettype wire

// ### verification/edge_capture_counter_link_tb_top.sv
// Purpose: Self-checking bench for the capture channel.
// Assumes: Inputs change 2 ns after the rising clock edge.
// Notes: Links are logged as {toOther, channel}.
`default_nettype none
module edge_capture_counter_link_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic capturePin;
	logic [7:0] filterLen = 8'h00;
	logic [23:0] primaryTimeCounter = 24'h00_0000;
	logic [23:0] secondaryTimeCounter = 24'h00_0000;
	logic initStrobe = 1'b0;
	logic channelEnable = 1'b0;
	logic [1:0] serviceLevel = 2'h0;
	logic [1:0] modeSelect = 2'h0;
	logic timebaseSelect = 1'b0;
	logic [1:0] polaritySelect = 2'h0;
	logic [23:0] edgeLimit = 24'h00_0000;
	logic [31:0] targetWordFirst = 32'h0588_08C8;
	logic [31:0] targetWordSecond = 32'h0000_0000;
	logic [7:0] targetCount = 8'h04;
	logic linkIn = 1'b0;
	logic [23:0] edgeCount, lastTime, finalTime;
	logic exceptionReq, captureDone, linkValid, linkToOther;
	logic [1:0] linkEngine, activeLevel;
	logic [5:0] linkChannel;
	logic [6:0] links[$];
	logic [23:0] stampRef;
	int nMismatch = 0;
	int checksDone = 0;
	int nExc = 0;
	int cyc = 0;
	ecc_pin_model i_pin (.clock(clock), .pinLevel(capturePin));
	ecc_channel i_dut (.clock(clock), .srst(srst), .capturePin(capturePin),
		.filterLen(filterLen), .primaryTimeCounter(primaryTimeCounter),
		.secondaryTimeCounter(secondaryTimeCounter), .initStrobe(initStrobe),
		.channelEnable(channelEnable), .serviceLevel(serviceLevel), .modeSelect(modeSelect),
		.timebaseSelect(timebaseSelect), .polaritySelect(polaritySelect), .edgeLimit(edgeLimit),
		.targetWordFirst(targetWordFirst), .targetWordSecond(targetWordSecond),
		.targetCount(targetCount), .linkIn(linkIn), .edgeCount(edgeCount), .lastTime(lastTime),
		.finalTime(finalTime), .exceptionReq(exceptionReq), .captureDone(captureDone),
		.linkValid(linkValid), .linkToOther(linkToOther), .linkEngine(linkEngine),
		.linkChannel(linkChannel), .activeLevel(activeLevel));
	always #10 clock = ~clock;
	always @(posedge clock) begin
		#2;
		primaryTimeCounter = primaryTimeCounter + 24'h00_0001;
		secondaryTimeCounter = secondaryTimeCounter + 24'h00_0003;
	end
	always @(posedge clock) begin
		if (exceptionReq === 1'b1) nExc++;
		if (linkValid === 1'b1) links.push_back({linkToOther, linkChannel});
		cyc++;
		if (cyc == 5000) begin
			nMismatch++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Disables first, then re-inits with the channel enabled.
	task automatic setup(input logic [1:0] md, pol, lvl, input logic tbs, input logic [23:0] lim);
		@(posedge clock) #2 channelEnable = 1'b0;
		@(posedge clock) #2 channelEnable = 1'b1;
		modeSelect = md;
		polaritySelect = pol;
		serviceLevel = lvl;
		timebaseSelect = tbs;
		edgeLimit = lim;
		initStrobe = 1'b1;
		@(posedge clock) #2 initStrobe = 1'b0;
		nExc = 0;
		links.delete();
	endtask
	// Target words are only taken by the channel at the next init.
	task automatic set_targets(input logic [31:0] wf, ws, input logic [7:0] n);
		@(posedge clock) #2 targetWordFirst = wf;
		targetWordSecond = ws;
		targetCount = n;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#2 srst = 1'b0;
		setup(2'h0, 2'h0, 2'h3, 1'b0, 24'h00_0001);
		i_pin.pulse(6);
		chk(edgeCount, 32'h0000_0001);
		chk(captureDone, 32'h0000_0001);
		chk(finalTime, lastTime);
		chk(nExc, 32'h0000_0001);
		i_pin.pulse(6);
		chk(edgeCount, 32'h0000_0001);
		for (int p = 0; p < 3; p++) begin
			setup(2'h1, p[1:0], 2'h2, p == 2, 24'h00_0002);
			i_pin.pulse(6);
			stampRef = lastTime;
			repeat (2) i_pin.pulse(6);
			chk(lastTime - stampRef, (p == 2) ? 32'h0000_0072 : 32'h0000_0026);
			chk(edgeCount, (p == 2) ? 32'h0000_0006 : 32'h0000_0003);
			chk(nExc, 32'h0000_0001);
			chk(captureDone, 32'h0000_0000);
		end
		#2 filterLen = 8'h04;
		setup(2'h1, 2'h2, 2'h1, 1'b1, 24'h00_0000);
		i_pin.pulse(2);
		chk(edgeCount, 32'h0000_0000);
		i_pin.pulse(8);
		chk(edgeCount, 32'h0000_0002);
		chk(nExc, 32'h0000_0000);
		#2 filterLen = 8'h00;
		linkIn = 1'b1;
		set_targets(32'h0588_08C8, 32'h0000_0000, 8'h04);
		setup(2'h2, 2'h0, 2'h3, 1'b0, 24'h00_0003);
		repeat (4) i_pin.pulse(6);
		chk(edgeCount, 32'h0000_0004);
		chk(links.size(), 32'h0000_0003);
		chk(links[0], 32'h0000_0068);
		chk(links[1], 32'h0000_0008);
		chk(links[2], 32'h0000_0005);
		#2 linkIn = 1'b0;
		set_targets(32'h0403_0201, 32'h80C5_4F07, 8'h08);
		setup(2'h2, 2'h0, 2'h3, 1'b0, 24'h00_0001);
		i_pin.pulse(6);
		chk(links.size(), 32'h0000_0007);
		chk(links[4], 32'h0000_0007);
		chk(links[5], 32'h0000_000F);
		chk(links[6], 32'h0000_0065);
		for (int v = 0; v < 4; v++) begin
			setup(2'h1, 2'h0, v[1:0], 1'b0, 24'h00_0001);
			i_pin.pulse(6);
			chk(activeLevel, v);
			chk(edgeCount, v != 0);
		end
		setup(2'h1, 2'h0, 2'h3, 1'b0, 24'h00_0001);
		@(posedge clock) #2 channelEnable = 1'b0;
		i_pin.pulse(6);
		chk(edgeCount, 32'h0000_0000);
		conclude();
	end
endmodule
`default_nettype wire
